// ### adcts_map.svh
// constants for the two-wire converter slave front end
// assumes inclusion by bare name from the slave module
`ifndef ADCTS_MAP_SVH
`define ADCTS_MAP_SVH

// field positions, shared by both written bytes
`define ADCTS_REG_BIT 7
// setup byte
`define ADCTS_SU_REF_HI 6
`define ADCTS_SU_REF_LO 4
`define ADCTS_SU_CLK 3
`define ADCTS_SU_POL 2
`define ADCTS_SU_RST 1
// configuration byte
`define ADCTS_CF_SCAN_HI 6
`define ADCTS_CF_SCAN_LO 5
`define ADCTS_CF_CS_HI 4
`define ADCTS_CF_CS_LO 1
`define ADCTS_CF_MODE 0

// reset values
`define ADCTS_SETUP_RST 8'h80
`define ADCTS_CONFIG_RST 8'h01

// bus codes
`define ADCTS_MCODE_TOP 5'h01
`define ADCTS_BITS_BYTE 4'h8
`define ADCTS_BITS_ACK 4'h9

// timing
`define ADCTS_CLK_NS 10
`define ADCTS_CONV_NS 7000
`define ADCTS_CONV_CYC ((`ADCTS_CONV_NS + `ADCTS_CLK_NS - 1) / `ADCTS_CLK_NS)
`define ADCTS_EXT_CLKS 4'hC

`endif

// ### adcts_pkg.sv
// types for the two-wire converter slave front end
// assumes adcts_map.svh is on the include path
package adcts_pkg;

  typedef struct packed {
    logic reg_bit;
    logic [2:0] ref_sel;
    logic clk_src;
    logic polarity;
    logic rst_keep;
    logic spare;
  } adcts_setup_t;

  typedef struct packed {
    logic reg_bit;
    logic [1:0] scan;
    logic [3:0] chan;
    logic input_mode;
  } adcts_config_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_AACK = 6'h04,
    ST_DATA = 6'h08,
    ST_DACK = 6'h10,
    ST_SKIP = 6'h20
  } adcts_state_t;

endpackage

// ### adcts_slave.sv
// two-wire slave front end of a 12-bit converter
// scl/sda are open drain; the bench resolves the wires from the enables
// analog_diff comes from the converter core on clk_sys
//
// Notes on behaviour
// - input mode 1 converts channel against ground, 0 converts a differential pair
// - in differential mode the polarity bit picks unipolar or bipolar
// - unipolar results clamp negative differential input to code zero
// - unipolar codes are straight binary, bipolar codes two's complement
// - single-ended conversions are always unipolar, polarity bit ignored
// - one bit per clock; a complete transfer needs at least nine clocks
// - data stable while clock high; changes then are control conditions
// - start is data falling with clock high, stop is data rising
// - repeated start keeps the bus active and the speed mode unchanged
// - acknowledge drives data low before and through the ninth clock high
// - not-acknowledge leaves data released through the ninth clock high
// - idle device waits for start plus own address; last bit gives direction
// - own address is acknowledged by pulling data low one clock
// - device starts in fast/standard speed mode after reset
// - master code 0000 1xxx gets not-acknowledge, then high-speed mode
// - any stop returns the device to fast/standard speed
// - written byte with top bit 1 goes to setup, 0 to configuration
// - one or two bytes in any order, each acknowledged
// - internal clock mode stretches the serial clock until conversion ends
// - input mode bit resets to single-ended
`timescale 1ns/1ps
`include "adcts_map.svh"

module adcts_slave import adcts_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int CONV_CYC = `ADCTS_CONV_CYC
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // serial clock as link clock
  input wire logic scl_clk,
  // serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // converter core
  input wire logic signed [12:0] analog_diff,
  // configuration to the core
  output logic [2:0] reference_select,
  output logic [1:0] scan_select,
  output logic [3:0] channel_select,
  output logic input_mode_select,
  output logic polarity_select,
  output logic clock_source,
  output logic high_speed_operation,
  // conversion result
  output logic [11:0] result_code,
  output logic result_valid
);

  // ****************************************
  // result formatting
  // ****************************************
  function automatic logic [11:0] fmt_code(
    input logic signed [12:0] d,
    input logic bip
  );
    logic [11:0] r;
    r = 12'h000;
    if (bip) begin
      if (d > 13'sh07FF) begin
        r = 12'h7FF;
      end else if (d < -13'sh0800) begin
        r = 12'h800;
      end else begin
        r = d[11:0];
      end
    end else begin
      if (d[12]) begin
        r = 12'h000;
      end else begin
        r = d[11:0];
      end
    end
    return r;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic scl_d_ff;
  logic sda_d_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic got_start;
  logic got_stop;

  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign got_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign got_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ****************************************
  // protocol state
  // ****************************************
  adcts_state_t state_ff;
  adcts_state_t nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic rw_ff;
  logic mcode_ff;
  logic ack_drive_ff;
  logic hs_ff;
  adcts_setup_t setup_ff;
  adcts_config_t config_ff;
  logic conv_go;

  logic addr_hit;
  logic mcode_hit;
  logic byte_end;
  logic ack_end;

  assign addr_hit = shift_ff[7:1] == DEV_ADDR;
  assign mcode_hit = shift_ff[7:3] == `ADCTS_MCODE_TOP;
  assign byte_end = scl_fall & (bit_cnt_ff == `ADCTS_BITS_BYTE);
  assign ack_end = scl_fall & (bit_cnt_ff == `ADCTS_BITS_ACK);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_IDLE;
      end
      ST_ADDR: begin
        if (byte_end) begin
          if (addr_hit || mcode_hit) begin
            nxt_state = ST_AACK;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_AACK: begin
        if (ack_end) begin
          if (mcode_ff) begin
            nxt_state = ST_IDLE;
          end else if (rw_ff) begin
            nxt_state = ST_SKIP;
          end else begin
            nxt_state = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (byte_end) begin
          nxt_state = ST_DACK;
        end
      end
      ST_DACK: begin
        if (ack_end) begin
          nxt_state = ST_DATA;
        end
      end
      ST_SKIP: begin
        nxt_state = ST_SKIP;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (got_start) begin
      nxt_state = ST_ADDR;
    end else if (got_stop) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // bit counter and shift register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else if (got_start || ack_end) begin
      bit_cnt_ff <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (bit_cnt_ff < `ADCTS_BITS_BYTE) begin
        shift_ff <= {shift_ff[6:0], sda_s};
      end
    end
  end

  // direction and master code capture
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rw_ff <= 1'b0;
      mcode_ff <= 1'b0;
    end else if (state_ff == ST_ADDR && byte_end) begin
      rw_ff <= shift_ff[0];
      mcode_ff <= ~addr_hit & mcode_hit;
    end
  end

  // acknowledge drive on the falling edge before the ninth clock
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ack_drive_ff <= 1'b0;
    end else if (got_start || got_stop || ack_end) begin
      ack_drive_ff <= 1'b0;
    end else if (state_ff == ST_ADDR && byte_end) begin
      ack_drive_ff <= addr_hit;
    end else if (state_ff == ST_DATA && byte_end) begin
      ack_drive_ff <= 1'b1;
    end
  end

  // speed mode
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hs_ff <= 1'b0;
    end else if (got_stop) begin
      hs_ff <= 1'b0;
    end else if (state_ff == ST_AACK && ack_end && mcode_ff) begin
      hs_ff <= 1'b1;
    end
  end

  // ****************************************
  // written registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      setup_ff <= `ADCTS_SETUP_RST;
    end else if (state_ff == ST_DATA && byte_end && shift_ff[`ADCTS_REG_BIT]) begin
      setup_ff <= shift_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      config_ff <= `ADCTS_CONFIG_RST;
    end else if (state_ff == ST_DATA && byte_end) begin
      if (!shift_ff[`ADCTS_REG_BIT]) begin
        config_ff <= shift_ff;
      end else if (!shift_ff[`ADCTS_SU_RST]) begin
        config_ff <= `ADCTS_CONFIG_RST;
      end
    end
  end

  // ****************************************
  // conversion control
  // ****************************************
  logic conv_busy_ff;
  logic [15:0] conv_cnt_ff;
  logic ext_mode_ff;
  logic req_tgl_ff;
  logic [1:0] done_sync_ff;
  logic done_seen_ff;
  logic done_tgl_ff;
  logic ext_done;

  // read address acknowledged starts a conversion
  assign conv_go = state_ff == ST_AACK && ack_end && rw_ff && !mcode_ff;
  assign ext_done = done_sync_ff[1] ^ done_seen_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      conv_busy_ff <= 1'b0;
      conv_cnt_ff <= 16'h0000;
      ext_mode_ff <= 1'b0;
    end else if (conv_go && !conv_busy_ff) begin
      conv_busy_ff <= 1'b1;
      ext_mode_ff <= setup_ff.clk_src;
      conv_cnt_ff <= CONV_CYC[15:0];
    end else if (conv_busy_ff) begin
      if (ext_mode_ff) begin
        if (ext_done || got_stop) begin
          conv_busy_ff <= 1'b0;
        end
      end else if (conv_cnt_ff <= 16'h0001) begin
        conv_busy_ff <= 1'b0;
      end else begin
        conv_cnt_ff <= conv_cnt_ff - 16'h0001;
      end
    end
  end

  // request toggle towards the serial clock domain
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      req_tgl_ff <= 1'b0;
    end else if (conv_go && !conv_busy_ff && setup_ff.clk_src) begin
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      done_sync_ff <= 2'h0;
      done_seen_ff <= 1'b0;
    end else begin
      done_sync_ff <= {done_sync_ff[0], done_tgl_ff};
      done_seen_ff <= done_sync_ff[1];
    end
  end

  // ****************************************
  // serial clock domain conversion timer
  // ****************************************
  logic [1:0] lrst_sync_ff;
  logic [1:0] req_sync_ff;
  logic req_seen_ff;
  logic [3:0] ext_cnt_ff;
  logic ext_run_ff;
  logic l_rst_b;

  assign l_rst_b = lrst_sync_ff[1];

  always_ff @(posedge scl_clk) begin
    lrst_sync_ff <= {lrst_sync_ff[0], rst_b};
  end

  always_ff @(posedge scl_clk) begin
    if (!l_rst_b) begin
      req_sync_ff <= 2'h0;
      req_seen_ff <= 1'b0;
      ext_cnt_ff <= 4'h0;
      ext_run_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
    end else begin
      req_sync_ff <= {req_sync_ff[0], req_tgl_ff};
      req_seen_ff <= req_sync_ff[1];
      if (req_sync_ff[1] ^ req_seen_ff) begin
        ext_run_ff <= 1'b1;
        ext_cnt_ff <= `ADCTS_EXT_CLKS;
      end else if (ext_run_ff) begin
        if (ext_cnt_ff == 4'h1) begin
          ext_run_ff <= 1'b0;
          done_tgl_ff <= ~done_tgl_ff;
        end
        ext_cnt_ff <= ext_cnt_ff - 4'h1;
      end
    end
  end

  // ****************************************
  // result capture
  // ****************************************
  logic conv_end;
  logic bipolar;

  assign conv_end = conv_busy_ff && ((ext_mode_ff && ext_done) ||
                    (!ext_mode_ff && conv_cnt_ff <= 16'h0001));
  assign bipolar = ~config_ff.input_mode & setup_ff.polarity;

  logic [11:0] result_ff;
  logic result_valid_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      result_ff <= 12'h000;
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= conv_end;
      if (conv_end) begin
        result_ff <= fmt_code(analog_diff, bipolar);
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic sda_oe_ff;
  logic scl_oe_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else begin
      sda_oe_ff <= ack_drive_ff & ~got_stop & ~got_start;
      scl_oe_ff <= (conv_go && !setup_ff.clk_src) ||
                   (conv_busy_ff && !ext_mode_ff && conv_cnt_ff > 16'h0002);
    end
  end

  logic zero_ff;

  always_ff @(posedge clk_sys) begin
    zero_ff <= 1'b0;
  end

  assign sda_o = zero_ff;
  assign sda_oe = sda_oe_ff;
  assign scl_o = zero_ff;
  assign scl_oe = scl_oe_ff;

  assign reference_select = setup_ff.ref_sel;
  assign polarity_select = setup_ff.polarity;
  assign clock_source = setup_ff.clk_src;
  assign scan_select = config_ff.scan;
  assign channel_select = config_ff.chan;
  assign input_mode_select = config_ff.input_mode;
  assign high_speed_operation = hs_ff;
  assign result_code = result_ff;
  assign result_valid = result_valid_ff;

endmodule

// ### adcts_checker_properties.sv
// pin-level assertions for the converter slave
// assumes a bind to adcts_slave, all in the clk_sys domain
`timescale 1ns/1ps
module adcts_checker #(
  parameter int CONV_CYC = 20
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // core side
  input wire logic signed [12:0] analog_diff,
  input wire logic input_mode_select,
  input wire logic polarity_select,
  input wire logic clock_source,
  input wire logic high_speed_operation,
  input wire logic [11:0] result_code,
  input wire logic result_valid
);
  // ****
  // stretch length
  // ****
  logic [15:0] st_ff;
  always_ff @(posedge clk_sys) begin
    st_ff <= (rst_b && scl_oe) ? st_ff + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ****
  // properties
  // ****
  AST_RST_STATE: assert property (disable iff (1'b0)
    !rst_b |=> !high_speed_operation && !sda_oe && !scl_oe && input_mode_select
    && !clock_source) else $error("state wrong after reset");
  AST_STRETCH_LEN: assert property (
    $fell(scl_oe) |-> st_ff >= CONV_CYC - 3 && st_ff <= CONV_CYC + 3)
    else $error("clock stretch length wrong");
  AST_EXT_NO_STRETCH: assert property (
    $rose(scl_oe) |-> !clock_source) else $error("stretch with serial clock source");
  AST_HS_STOP: assert property (
    $rose(sda_i) && scl_i |-> ##[1:8] !high_speed_operation)
    else $error("high speed kept after stop");
  AST_HS_KEEP: assert property (
    $fell(sda_i) && scl_i && high_speed_operation |-> high_speed_operation[*8])
    else $error("high speed lost on repeated start");
  AST_HS_NAK: assert property (
    $rose(high_speed_operation) |-> !sda_oe && !$past(sda_oe, 6))
    else $error("master code was acknowledged");
  AST_UNI_NEG: assert property (
    result_valid && (input_mode_select || !polarity_select) && analog_diff[12]
    |-> result_code == 12'h000) else $error("negative unipolar not zero");
  AST_BIP_CODE: assert property (
    result_valid && polarity_select && !input_mode_select
    && analog_diff[12] == analog_diff[11] |-> result_code == analog_diff[11:0])
    else $error("bipolar code wrong");
endmodule

// ### adcts_mst.sv
// two-wire bus master model
// assumes the bench resolves pull-ups; the slave may stretch the clock
`timescale 1ns/1ps
module adcts_mst (
  // resolved wires
  input wire logic scl,
  input wire logic sda,
  // pull-downs, high pulls the line low
  output logic drv_scl,
  output logic drv_sda
);
  localparam int H = 32;
  initial begin
    drv_scl = 1'b0;
    drv_sda = 1'b0;
  end
  // ****
  // bus tasks
  // ****
  // releases the clock and waits out a stretch, bounded
  task automatic rel();
    int n;
    n = 0;
    drv_scl = 1'b0;
    while (scl !== 1'b1 && n < 2000) begin
      #2;
      n++;
    end
  endtask
  task automatic start();
    #H drv_sda = 1'b0;
    #H rel();
    #H drv_sda = 1'b1;
    #H drv_scl = 1'b1;
  endtask
  task automatic stop();
    #H drv_sda = 1'b1;
    #H rel();
    #H drv_sda = 1'b0;
  endtask
  // data moves mid-low only
  task automatic bit_io(input logic b, input int lo, output logic r);
    #(lo - H / 2) drv_sda = !b;
    #(H / 2) rel();
    #(H - 2) r = sda;
    #2 drv_scl = 1'b1;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], H, r);
    end
    bit_io(1'b1, 2 * H, r);
    ack = !r;
    #H;
  endtask
endmodule

// ### testbench.sv
// self-checking bench for the two-wire converter slave
// assumes package, slave, master model and checker compiled first
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam int CONV_CYC = 20;
  logic clk_sys, rst_b, drv_scl, drv_sda, scl_oe, sda_oe, result_valid;
  logic signed [12:0] analog_diff;
  logic [2:0] reference_select;
  logic [1:0] scan_select;
  logic [3:0] channel_select;
  logic input_mode_select, polarity_select, clock_source, high_speed_operation;
  logic [11:0] result_code, last_code;
  wire scl, sda;
  int miscompares = 0;
  int compares = 0;
  int n_valid = 0;
  // pull-ups on both lines
  assign scl = !(drv_scl || scl_oe);
  assign sda = !(drv_sda || sda_oe);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  adcts_slave #(.DEV_ADDR(ADDR), .CONV_CYC(CONV_CYC)) i_adcts_slave (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl_clk(scl), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .analog_diff(analog_diff),
    .reference_select(reference_select), .scan_select(scan_select),
    .channel_select(channel_select), .input_mode_select(input_mode_select),
    .polarity_select(polarity_select), .clock_source(clock_source),
    .high_speed_operation(high_speed_operation), .result_code(result_code),
    .result_valid(result_valid));
  adcts_mst i_adcts_mst (.scl(scl), .sda(sda), .drv_scl(drv_scl), .drv_sda(drv_sda));
  always @(posedge clk_sys) begin
    if (result_valid === 1'b1) begin
      last_code <= result_code;
      n_valid <= n_valid + 1;
    end
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] d, input logic exp);
    logic a;
    i_adcts_mst.put(d, a);
    chk({15'h0000, a}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [7:0] d);
    i_adcts_mst.start();
    xfer({ADDR, 1'b0}, 1'b1);
    xfer(d, 1'b1);
    i_adcts_mst.stop();
  endtask
  task automatic regs(input logic [4:0] su, input logic [6:0] cf);
    chk({11'h000, reference_select, clock_source, polarity_select}, {11'h000, su});
    chk({9'h000, scan_select, channel_select, input_mode_select}, {9'h000, cf});
  endtask
  task automatic hs(input logic exp);
    repeat (8) @(posedge clk_sys);
    #1 chk({15'h0000, high_speed_operation}, {15'h0000, exp});
  endtask
  task automatic rd(input logic [12:0] v, input logic [11:0] exp, input logic ext);
    int n0;
    logic a;
    n0 = n_valid;
    @(posedge clk_sys);
    #1 analog_diff = v;
    i_adcts_mst.start();
    xfer({ADDR, 1'b1}, 1'b1);
    if (ext) begin
      i_adcts_mst.put(8'hFF, a);
      i_adcts_mst.put(8'hFF, a);
    end
    i_adcts_mst.stop();
    repeat (8) @(posedge clk_sys);
    #1 chk(16'(n_valid - n0), 16'h0001);
    chk({4'h0, last_code}, {4'h0, exp});
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    #500000;
    miscompares++;
    summarize();
  end
  initial begin
    logic r;
    rst_b = 1'b0;
    analog_diff = 13'h0000;
    repeat (3) i_adcts_mst.bit_io(1'b1, 32, r);
    i_adcts_mst.rel();
    @(posedge clk_sys);
    #1 rst_b = 1'b1;
    regs(5'h00, 7'h01);
    hs(1'b0);
    i_adcts_mst.start();
    xfer({ADDR, 1'b0}, 1'b1);
    xfer(8'hD6, 1'b1);
    xfer(8'h3A, 1'b1);
    i_adcts_mst.stop();
    regs(5'h15, 7'h3A);
    i_adcts_mst.start();
    xfer({ADDR ^ 7'h01, 1'b0}, 1'b0);
    xfer(8'h80, 1'b0);
    i_adcts_mst.stop();
    regs(5'h15, 7'h3A);
    wr(8'hD4);
    regs(5'h15, 7'h01);
    wr(8'h3A);
    wr(8'hD6);
    regs(5'h15, 7'h3A);
    rd(13'h1FFB, 12'hFFB, 1'b0);
    wr(8'hD2);
    rd(13'h1FFB, 12'h000, 1'b0);
    rd(13'h0123, 12'h123, 1'b0);
    wr(8'h3B);
    wr(8'hD6);
    rd(13'h1FFB, 12'h000, 1'b0);
    rd(13'h0456, 12'h456, 1'b0);
    wr(8'hDE);
    regs(5'h17, 7'h3B);
    rd(13'h0321, 12'h321, 1'b1);
    for (int i = 0; i < 8; i++) begin
      i_adcts_mst.start();
      xfer({5'h01, i[2:0]}, 1'b0);
      hs(1'b1);
      i_adcts_mst.stop();
      hs(1'b0);
    end
    i_adcts_mst.start();
    xfer(8'h0B, 1'b0);
    i_adcts_mst.start();
    xfer({ADDR, 1'b0}, 1'b1);
    xfer(8'h3A, 1'b1);
    hs(1'b1);
    i_adcts_mst.stop();
    hs(1'b0);
    summarize();
  end
endmodule
bind adcts_slave adcts_checker #(.CONV_CYC(CONV_CYC)) i_adcts_checker (
  .clk_sys(clk_sys), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .analog_diff(analog_diff), .input_mode_select(input_mode_select),
  .polarity_select(polarity_select), .clock_source(clock_source),
  .high_speed_operation(high_speed_operation), .result_code(result_code),
  .result_valid(result_valid));
